// file: pio_board_model.sv
// Purpose: Board around ports 0-2, resolving each pin from drive and board level
// Assumes: Board levels are strong enough to override an idle pull-up
// Notes: Undriven bits show the board level, driven bits show the pin driver
`timescale 1ns/1ps
`default_nettype none
module pio_board_model (
    input wire pio_pkg::pio_pin_drv_t p0_pins,
    input wire pio_pkg::pio_pin_drv_t p1_pins,
    input wire pio_pkg::pio_pin_drv_t p2_pins,
    input wire logic [7:0] ext0,
    input wire logic [7:0] ext1,
    input wire logic [7:0] ext2,
    output logic [7:0] p0_in,
    output logic [7:0] p1_in,
    output logic [7:0] p2_in
);
    import pio_pkg::*;
    // A driven bit wins over the board, so open-drain low always shows
    assign p0_in = (p0_pins.oe & p0_pins.out) | (~p0_pins.oe & ext0);
    assign p1_in = (p1_pins.oe & p1_pins.out) | (~p1_pins.oe & ext1);
    assign p2_in = (p2_pins.oe & p2_pins.out) | (~p2_pins.oe & ext2);
endmodule
`default_nettype wire

// file: pio_edge_det.sv
// Purpose: Edge detector with selectable rising, falling or both edges
// Assumes: Level is synchronous to sys_clk
// Notes: One cycle combinational pulse, in the same cycle the edge is seen
`timescale 1ns/1ps
`default_nettype none
module pio_edge_det (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic level,
    input wire logic [1:0] mode,
    output logic pulse
);
    import pio_pkg::*;
    logic prev_reg;
    logic rise;
    logic fall;

    always_ff @(posedge sys_clk) begin
        // Track the pin through reset so a high idle level gives no false edge
        if (rst) begin
            prev_reg <= level;
        end else begin
            prev_reg <= level;
        end
    end

    assign rise = level & ~prev_reg;
    assign fall = ~level & prev_reg;

    always_comb begin
        case (mode)
            EDGE_RISE: pulse = rise;
            EDGE_FALL: pulse = fall;
            default: pulse = rise | fall;
        endcase
    end
endmodule
`default_nettype wire

// file: pio_pkg.sv
// Purpose: Shared constants and carrier types for the port I/O block
// Assumes: 8-bit register port, one clock domain
// Notes: Offsets are byte addresses on the plain register port
package pio_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [7:0] ADDR_P0_DATA = 8'h00;
    localparam logic [7:0] ADDR_P1_DATA = 8'h01;
    localparam logic [7:0] ADDR_P2_DATA = 8'h02;
    localparam logic [7:0] ADDR_P3_DATA = 8'h03;
    localparam logic [7:0] ADDR_P0_DIR = 8'h04;
    localparam logic [7:0] ADDR_P1_DIR = 8'h05;
    localparam logic [7:0] ADDR_P2_DIR = 8'h06;
    localparam logic [7:0] ADDR_P3_MODE = 8'h07;
    localparam logic [7:0] ADDR_PORT_CFG = 8'h08;
    localparam logic [7:0] ADDR_IRQ_CFG = 8'h09;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h0a;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0b;
    localparam logic [7:0] ADDR_TMR_SEL = 8'h0c;
    // Read-modify-write window: base | op<<2 | port
    localparam logic [7:0] ADDR_RMW_BASE = 8'h10;
    localparam logic [3:0] RMW_HI_NIBBLE = 4'h1;
    localparam logic [1:0] RMW_OP_OR = 2'h1;
    localparam logic [1:0] RMW_OP_AND = 2'h2;
    localparam logic [1:0] RMW_OP_XOR = 2'h3;

    // Field positions
    localparam int P3_MODE_ANALOG_BIT = 1;
    localparam int CFG_CMP_OUT_BIT = 0;
    localparam int CFG_P1_PP_BIT = 1;
    localparam int CFG_P0_PP_BIT = 2;
    localparam int IRQ_EDGE_LSB = 6;
    localparam int TMR_SEL_BIT = 0;
    localparam int REF_PIN_BIT = 3;
    localparam int CMP_A_BIT = 1;
    localparam int CMP_B_BIT = 2;
    localparam int STAT_CMP_A = 0;
    localparam int STAT_CMP_B = 1;
    localparam int STAT_IRQ_ONE = 2;
    localparam int NUM_EVENTS = 3;

    // Reset values
    localparam logic [7:0] RST_DATA = 8'h00;
    localparam logic [7:0] RST_DIR = 8'hff;
    localparam logic [7:0] RST_CFG = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;

    // Edge selection codes
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic we;
        logic re;
    } pio_bus_t;

    typedef struct packed {
        logic [7:0] out;
        logic [7:0] oe;
        logic [7:0] pu;
    } pio_pin_drv_t;
endpackage

// file: pio_port_drv.sv
// Purpose: Output driver, open-drain option and pull-up control of one port
// Assumes: Direction bit one means input
// Notes: Open-drain only ever drives low
`timescale 1ns/1ps
`default_nettype none
module pio_port_drv #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] out_val,
    input wire logic [WIDTH-1:0] dir_in,
    input wire logic push_pull,
    output var pio_pkg::pio_pin_drv_t drv
);
    import pio_pkg::*;
    always_comb begin
        // Open-drain lets the pin float high instead of driving it
        drv.out = push_pull ? out_val : '0;
        drv.oe = ~dir_in & (push_pull ? {WIDTH{1'b1}} : ~out_val);
        // Pull-up follows direction only
        drv.pu = dir_in;
    end
endmodule
`default_nettype wire

// file: pio_port_top.sv
// Purpose: Ports 0-3 with comparator inputs, interrupts and output routing
// Assumes: Pin levels and comparator results synchronous to sys_clk
// Notes: Port 3 pins 0-3 are inputs, pins 4-7 are outputs
//
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module pio_port_top (
    input wire logic sys_clk,
    input wire logic rst,
    input wire pio_pkg::pio_bus_t bus,
    output logic [7:0] rdata,
    input wire logic [7:0] p0_in,
    output var pio_pkg::pio_pin_drv_t p0_pins,
    input wire logic [7:0] p1_in,
    output var pio_pkg::pio_pin_drv_t p1_pins,
    input wire logic [7:0] p2_in,
    output var pio_pkg::pio_pin_drv_t p2_pins,
    input wire logic [3:0] p3_in,
    input wire logic cmp_a_raw,
    input wire logic cmp_b_raw,
    output logic [3:0] p3_out,
    input wire logic stop_mode,
    output logic cmp_power_en,
    output logic timer_edge_in,
    output logic [3:0] stop_recovery_sources,
    output logic irq
);
    import pio_pkg::*;

    logic [7:0] out_reg [4];
    logic [7:0] out_next [4];
    logic [7:0] dir_reg [3];
    logic [7:0] p3_mode_reg;
    logic [7:0] port_config_reg;
    logic [7:0] irq_cfg_reg;
    logic [7:0] tmr_sel_reg;
    logic [NUM_EVENTS-1:0] stat_reg;
    logic [NUM_EVENTS-1:0] stat_next;
    logic [NUM_EVENTS-1:0] mask_reg;
    logic [7:0] rdata_next;
    logic [7:0] pin_val [4];
    logic analog;
    logic cmp_a_res;
    logic cmp_b_res;
    logic cmp_in_a_pin;
    logic cmp_in_b_pin;
    logic cmp_ref_b_pin;
    logic edge_a;
    logic edge_b;
    logic edge_ref;
    logic [1:0] edge_mode;
    logic rmw_hit;
    logic [1:0] rmw_op;
    logic [1:0] rmw_port;
    logic [NUM_EVENTS-1:0] evt_set;

    assign analog = p3_mode_reg[P3_MODE_ANALOG_BIT];
    // Comparators sleep in stop mode, so their results read low
    assign cmp_power_en = analog & ~stop_mode;
    assign cmp_a_res = cmp_power_en & cmp_a_raw;
    assign cmp_b_res = cmp_power_en & cmp_b_raw;

    assign cmp_ref_b_pin = p3_in[REF_PIN_BIT];
    assign cmp_in_a_pin = analog ? cmp_a_res : p3_in[CMP_A_BIT];
    assign cmp_in_b_pin = analog ? cmp_b_res : p3_in[CMP_B_BIT];

    // Pin view used by reads and by read-modify-write
    always_comb begin
        pin_val[0] = p0_in;
        pin_val[1] = p1_in;
        pin_val[2] = p2_in;
        pin_val[3] = {p3_out, analog ? 1'b0 : cmp_ref_b_pin, cmp_in_b_pin, cmp_in_a_pin, p3_in[0]};
    end

    assign rmw_hit = bus.we && (bus.addr[7:4] == RMW_HI_NIBBLE) && (bus.addr[3:2] != 2'h0);
    assign rmw_op = bus.addr[3:2];
    assign rmw_port = bus.addr[1:0];

    // Output data registers, plain and read-modify-write
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            out_next[i] = out_reg[i];
        end
        if (bus.we && bus.addr[7:2] == 6'h00) begin
            out_next[bus.addr[1:0]] = bus.wdata;
        end
        if (rmw_hit) begin
            case (rmw_op)
                RMW_OP_OR: out_next[rmw_port] = pin_val[rmw_port] | bus.wdata;
                RMW_OP_AND: out_next[rmw_port] = pin_val[rmw_port] & bus.wdata;
                RMW_OP_XOR: out_next[rmw_port] = pin_val[rmw_port] ^ bus.wdata;
                default: out_next[rmw_port] = out_reg[rmw_port];
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) begin
                out_reg[i] <= RST_DATA;
            end
        end else begin
            for (int i = 0; i < 4; i++) begin
                out_reg[i] <= out_next[i];
            end
        end
    end

    // Direction and configuration registers
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            for (int i = 0; i < 3; i++) begin
                dir_reg[i] <= RST_DIR;
            end
            p3_mode_reg <= RST_ZERO;
            port_config_reg <= RST_CFG;
            irq_cfg_reg <= RST_ZERO;
            tmr_sel_reg <= RST_ZERO;
            mask_reg <= '0;
        end else if (bus.we) begin
            case (bus.addr)
                ADDR_P0_DIR: dir_reg[0] <= bus.wdata;
                ADDR_P1_DIR: dir_reg[1] <= bus.wdata;
                ADDR_P2_DIR: dir_reg[2] <= bus.wdata;
                ADDR_P3_MODE: p3_mode_reg <= bus.wdata;
                ADDR_PORT_CFG: port_config_reg <= bus.wdata;
                ADDR_IRQ_CFG: irq_cfg_reg <= bus.wdata;
                ADDR_TMR_SEL: tmr_sel_reg <= bus.wdata;
                ADDR_IRQ_MASK: mask_reg <= bus.wdata[NUM_EVENTS-1:0];
                default: ;
            endcase
        end
    end

    // Edge detection on the comparator inputs and reference pin
    assign edge_mode = irq_cfg_reg[IRQ_EDGE_LSB +: 2];

    pio_edge_det u_edge_a (
        .sys_clk(sys_clk),
        .rst(rst),
        .level(cmp_in_a_pin),
        .mode(edge_mode),
        .pulse(edge_a)
    );

    pio_edge_det u_edge_b (
        .sys_clk(sys_clk),
        .rst(rst),
        .level(cmp_in_b_pin),
        .mode(edge_mode),
        .pulse(edge_b)
    );

    pio_edge_det u_edge_ref (
        .sys_clk(sys_clk),
        .rst(rst),
        .level(cmp_ref_b_pin),
        .mode(EDGE_FALL),
        .pulse(edge_ref)
    );

    // Reference pin event only reaches the interrupt in digital mode
    assign evt_set = {edge_ref & ~analog, edge_b, edge_a};

    // Set wins over a same-cycle write-one clear
    always_comb begin
        stat_next = stat_reg;
        if (bus.we && bus.addr == ADDR_IRQ_STAT) begin
            stat_next = stat_reg & ~bus.wdata[NUM_EVENTS-1:0];
        end
        stat_next = stat_next | evt_set;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stat_reg <= '0;
        end else begin
            stat_reg <= stat_next;
        end
    end

    assign irq = |(stat_reg & mask_reg);

    // Stop recovery sources: pins 1-3 in digital mode, ref latch in analog
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            stop_recovery_sources <= 4'h0;
        end else begin
            stop_recovery_sources[2:0] <= analog ? 3'h0 : p3_in[3:1];
            stop_recovery_sources[3] <= analog & cmp_ref_b_pin;
        end
    end

    // Timer edge input selection
    assign timer_edge_in = tmr_sel_reg[TMR_SEL_BIT] ? p2_in[0] : cmp_in_a_pin;

    // Port 3 outputs: comparator results may replace pins 4 and 7
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            p3_out <= 4'h0;
        end else if (port_config_reg[CFG_CMP_OUT_BIT]) begin
            p3_out <= {cmp_b_res, out_next[3][6:5], cmp_a_res};
        end else begin
            p3_out <= out_next[3][7:4];
        end
    end

    // Port drivers
    pio_port_drv #(.WIDTH(8)) u_drv0 (
        .out_val(out_reg[0]),
        .dir_in(dir_reg[0]),
        .push_pull(port_config_reg[CFG_P0_PP_BIT]),
        .drv(p0_pins)
    );

    pio_port_drv #(.WIDTH(8)) u_drv1 (
        .out_val(out_reg[1]),
        .dir_in(dir_reg[1]),
        .push_pull(port_config_reg[CFG_P1_PP_BIT]),
        .drv(p1_pins)
    );

    // Port 2 has no open-drain option here
    pio_port_drv #(.WIDTH(8)) u_drv2 (
        .out_val(out_reg[2]),
        .dir_in(dir_reg[2]),
        .push_pull(1'b1),
        .drv(p2_pins)
    );

    // Read path, data one cycle after the strobe
    always_comb begin
        rdata_next = 8'h00;
        case (bus.addr)
            ADDR_P0_DATA: rdata_next = pin_val[0];
            ADDR_P1_DATA: rdata_next = pin_val[1];
            ADDR_P2_DATA: rdata_next = pin_val[2];
            ADDR_P3_DATA: rdata_next = pin_val[3];
            ADDR_P0_DIR: rdata_next = dir_reg[0];
            ADDR_P1_DIR: rdata_next = dir_reg[1];
            ADDR_P2_DIR: rdata_next = dir_reg[2];
            ADDR_P3_MODE: rdata_next = p3_mode_reg;
            ADDR_PORT_CFG: rdata_next = port_config_reg;
            ADDR_IRQ_CFG: rdata_next = irq_cfg_reg;
            ADDR_IRQ_STAT: rdata_next = {5'h00, stat_reg};
            ADDR_IRQ_MASK: rdata_next = {5'h00, mask_reg};
            ADDR_TMR_SEL: rdata_next = tmr_sel_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (bus.re) begin
            rdata <= rdata_next;
        end else begin
            rdata <= 8'h00;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    property p_pullup_off;
        !(|(~dir_reg[1] & p1_pins.pu));
    endproperty
    a_pullup_off: assert property (p_pullup_off) else $error("pull-up on output pin");

    property p_pullup_back;
        bus.we && bus.addr == ADDR_P0_DIR |=> p0_pins.pu == $past(bus.wdata);
    endproperty
    a_pullup_back: assert property (p_pullup_back) else $error("pull-up not following dir");

    property p_read_pins;
        bus.re && bus.addr == ADDR_P1_DATA |=> rdata == $past(p1_in);
    endproperty
    a_read_pins: assert property (p_read_pins) else $error("port read not from pins");

    property p_rmw_xor;
        bus.we && bus.addr == (ADDR_RMW_BASE | 8'h0c) |=> out_reg[0] == ($past(p0_in) ^ $past(bus.wdata));
    endproperty
    a_rmw_xor: assert property (p_rmw_xor) else $error("xor not read-modify-write");

    property p_cmp_enable;
        cmp_power_en == (p3_mode_reg[1] && !stop_mode);
    endproperty
    a_cmp_enable: assert property (p_cmp_enable) else $error("comparator power wrong");

    property p_edge_cause;
        $rose(stat_reg[STAT_CMP_A]) |-> $past(edge_a);
    endproperty
    a_edge_cause: assert property (p_edge_cause) else $error("status A set without edge");

    property p_rise_sets;
        edge_mode == EDGE_RISE && !cmp_in_a_pin ##1 cmp_in_a_pin |=> stat_reg[STAT_CMP_A];
    endproperty
    a_rise_sets: assert property (p_rise_sets) else $error("rising edge missed");

    property p_timer_src;
        timer_edge_in == (tmr_sel_reg[0] ? p2_in[0] : cmp_in_a_pin);
    endproperty
    a_timer_src: assert property (p_timer_src) else $error("timer input wrong");

    property p_ref_divert;
        $rose(stat_reg[STAT_IRQ_ONE]) |-> !$past(analog);
    endproperty
    a_ref_divert: assert property (p_ref_divert) else $error("ref irq in analog mode");

    property p_cmp_out;
        port_config_reg[0] |=> p3_out[0] == $past(cmp_a_res) && p3_out[3] == $past(cmp_b_res);
    endproperty
    a_cmp_out: assert property (p_cmp_out) else $error("comparator output not routed");

    property p_od_p1;
        !port_config_reg[1] |-> p1_pins.out == 8'h00;
    endproperty
    a_od_p1: assert property (p_od_p1) else $error("port 1 drives high in open-drain");

    property p_od_p0;
        !port_config_reg[2] |-> !(|(p0_pins.oe & out_reg[0]));
    endproperty
    a_od_p0: assert property (p_od_p0) else $error("port 0 enabled high in open-drain");

    c_irq: cover property (irq);
    c_rmw: cover property (rmw_hit);
    c_analog_edge: cover property (analog && edge_a);
    c_cmp_route: cover property (port_config_reg[0] && p3_out[3]);
endmodule
`default_nettype wire

// file: port_io_comparator_routing_tb_top.sv
// Purpose: Self-checking bench of the port block
// Assumes: Register port without wait states
// Notes: Edge checks allow three cycles for the registered status
`timescale 1ns/1ps
`default_nettype none
module port_io_comparator_routing_tb_top;
    import pio_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    pio_bus_t bus = '0;
    logic [7:0] rdata, p0_in, p1_in, p2_in;
    logic [7:0] ext0 = 8'hff, ext1 = 8'hff, ext2 = 8'hff;
    pio_pin_drv_t p0_pins, p1_pins, p2_pins;
    logic [3:0] p3_in = 4'h0;
    logic cmp_a_raw = 1'b0, cmp_b_raw = 1'b0, stop_mode = 1'b0;
    logic [3:0] p3_out, srs;
    logic cmp_power_en, timer_edge_in, irq;
    int fails = 0;
    int num_checks = 0;

    pio_port_top dut (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata), .p0_in(p0_in),
        .p0_pins(p0_pins), .p1_in(p1_in), .p1_pins(p1_pins), .p2_in(p2_in), .p2_pins(p2_pins),
        .p3_in(p3_in), .cmp_a_raw(cmp_a_raw), .cmp_b_raw(cmp_b_raw), .p3_out(p3_out),
        .stop_mode(stop_mode), .cmp_power_en(cmp_power_en), .timer_edge_in(timer_edge_in),
        .stop_recovery_sources(srs), .irq(irq));
    pio_board_model board (.p0_pins(p0_pins), .p1_pins(p1_pins), .p2_pins(p2_pins), .ext0(ext0),
        .ext1(ext1), .ext2(ext2), .p0_in(p0_in), .p1_in(p1_in), .p2_in(p2_in));

    initial begin
        forever #2 sys_clk = ~sys_clk;
    end

    task automatic test_done;
        if (fails == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
        @(posedge sys_clk);
        bus.we <= 1'b0;
        #1;
    endtask

    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
        @(posedge sys_clk);
        bus.re <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask

    task automatic t_pullup;
        chk("reset pu", 8'hff, p0_pins.pu);
        chk("reset oe", 8'h00, p0_pins.oe);
        wr(ADDR_P0_DIR, 8'h0f);
        chk("p0 pu", 8'h0f, p0_pins.pu);
        chk("p0 oe", 8'hf0, p0_pins.oe);
        wr(ADDR_P0_DIR, 8'hff);
        chk("p0 pu back", 8'hff, p0_pins.pu);
        rd("unmapped", 8'h3f, 8'h00);
        wr(ADDR_P2_DATA, 8'h5a);
        wr(ADDR_P2_DIR, 8'h0f);
        chk("p2 pu", 8'h0f, p2_pins.pu);
        chk("p2 oe", 8'hf0, p2_pins.oe);
        rd("p2 read", ADDR_P2_DATA, 8'h5f);
    endtask

    task automatic t_modes;
        logic [7:0] cfgs [4] = '{8'h00, 8'h02, 8'h04, 8'h06};
        @(posedge sys_clk) ext0 <= 8'h3c;
        ext1 <= 8'h3c;
        wr(ADDR_P0_DATA, 8'ha5);
        wr(ADDR_P1_DATA, 8'ha5);
        wr(ADDR_P0_DIR, 8'h00);
        wr(ADDR_P1_DIR, 8'h00);
        chk("p1 pu out", 8'h00, p1_pins.pu);
        foreach (cfgs[i]) begin
            wr(ADDR_PORT_CFG, cfgs[i]);
            rd("p0 read", ADDR_P0_DATA, cfgs[i][2] ? 8'ha5 : 8'h24);
            rd("p1 read", ADDR_P1_DATA, cfgs[i][1] ? 8'ha5 : 8'h24);
        end
    endtask

    task automatic t_rmw;
        // Open-drain with board at 3c: pins differ from the output register
        logic [1:0] ops [3] = '{RMW_OP_OR, RMW_OP_AND, RMW_OP_XOR};
        logic [7:0] arg [3] = '{8'h01, 8'hf0, 8'hff};
        logic [7:0] oe_e [3] = '{8'hda, 8'hdf, 8'h20};
        wr(ADDR_PORT_CFG, 8'h00);
        wr(ADDR_P1_DATA, 8'ha5);
        foreach (ops[i]) begin
            wr({RMW_HI_NIBBLE, ops[i], 2'h1}, arg[i]);
            chk("rmw oe", oe_e[i], p1_pins.oe);
        end
    endtask

    task automatic t_edges;
        wr(ADDR_P3_MODE, 8'h02);
        chk("power", 8'h01, {7'h0, cmp_power_en});
        @(posedge sys_clk) cmp_a_raw <= 1'b1;
        rd("p3 analog", ADDR_P3_DATA, 8'h02);
        @(posedge sys_clk) cmp_a_raw <= 1'b0;
        wr(ADDR_IRQ_MASK, 8'h01);
        for (int m = 0; m < 3; m++) begin
            wr(ADDR_IRQ_CFG, 8'(m << IRQ_EDGE_LSB));
            wr(ADDR_IRQ_STAT, 8'hff);
            @(posedge sys_clk) cmp_a_raw <= 1'b1;
            cyc(3);
            chk("irq rise", {7'h0, m != 1}, {7'h0, irq});
            rd("stat rise", ADDR_IRQ_STAT, {7'h0, m != 1});
            wr(ADDR_IRQ_STAT, 8'hff);
            @(posedge sys_clk) cmp_a_raw <= 1'b0;
            cyc(3);
            rd("stat fall", ADDR_IRQ_STAT, {7'h0, m != 0});
        end
        wr(ADDR_IRQ_MASK, 8'h00);
        chk("irq masked", 8'h00, {7'h0, irq});
        wr(ADDR_IRQ_STAT, 8'h01);
    endtask

    task automatic t_ref;
        wr(ADDR_IRQ_MASK, 8'h04);
        @(posedge sys_clk) p3_in <= 4'h8;
        cyc(3);
        chk("srs analog", 8'h08, {4'h0, srs});
        wr(ADDR_IRQ_STAT, 8'hff);
        @(posedge sys_clk) p3_in <= 4'h0;
        cyc(3);
        rd("stat analog", ADDR_IRQ_STAT, 8'h00);
        wr(ADDR_P3_MODE, 8'h00);
        chk("power off", 8'h00, {7'h0, cmp_power_en});
        @(posedge sys_clk) p3_in <= 4'he;
        cyc(3);
        chk("srs digital", 8'h07, {4'h0, srs});
        rd("p3 digital", ADDR_P3_DATA, 8'h0e);
        wr(ADDR_IRQ_STAT, 8'hff);
        @(posedge sys_clk) p3_in <= 4'h6;
        cyc(3);
        chk("irq one", 8'h01, {7'h0, irq});
        rd("stat one", ADDR_IRQ_STAT, 8'h04);
        wr(ADDR_IRQ_STAT, 8'h04);
        chk("irq clear", 8'h00, {7'h0, irq});
    endtask

    task automatic t_timer;
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_TMR_SEL, {7'h0, k[1]});
            // Opposite levels on the two sources so the selection shows
            @(posedge sys_clk) p3_in <= {2'h0, k[0], 1'b0};
            ext2 <= {7'h7f, ~k[0]};
            cyc(1);
            chk("timer src", {7'h0, k[0] ^ k[1]}, {7'h0, timer_edge_in});
        end
    endtask

    task automatic t_stop_route;
        wr(ADDR_P3_MODE, 8'h02);
        @(posedge sys_clk) stop_mode <= 1'b1;
        cyc(1);
        chk("stop power", 8'h00, {7'h0, cmp_power_en});
        @(posedge sys_clk) stop_mode <= 1'b0;
        cmp_b_raw <= 1'b1;
        wr(ADDR_P3_DATA, 8'h50);
        wr(ADDR_PORT_CFG, 8'h01);
        cyc(2);
        chk("routed", 8'h0c, {4'h0, p3_out});
        wr(ADDR_PORT_CFG, 8'h00);
        cyc(2);
        chk("plain io", 8'h05, {4'h0, p3_out});
    endtask

    initial begin
        #200000;
        fails++;
        test_done();
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        cyc(1);
        chk("reset p3", 8'h00, {4'h0, p3_out});
        t_pullup();
        t_modes();
        t_rmw();
        t_edges();
        t_ref();
        t_timer();
        t_stop_route();
        test_done();
    end
endmodule
`default_nettype wire
